// *** include/thc_map.vh ***
// register offsets, field positions, reset values and timing counts
`ifndef THC_MAP_VH
`define THC_MAP_VH
`define THC_OFF_CTRL      8'h00
`define THC_OFF_TEMP      8'h04
`define THC_OFF_SP_BASE   8'h08
`define THC_OFF_HYST      8'h28
`define THC_OFF_PI        8'h2C
`define THC_OFF_CYCLE     8'h30
`define THC_OFF_STATUS    8'h34
`define THC_OFF_CV        8'h38
`define THC_CTRL_HEAT     0
`define THC_CTRL_ALT      1
`define THC_CTRL_ALG_LO   2
`define THC_CTRL_ALG_HI   3
`define THC_CTRL_MODE_LO  4
`define THC_CTRL_MODE_HI  5
`define THC_CTRL_TERM_LO  6
`define THC_CTRL_TERM_HI  8
`define THC_ALG_TWO_POINT 2'h0
`define THC_ALG_PI_CONT   2'h1
`define THC_ALG_PI_PWM    2'h2
`define THC_TERM_FLOOR    3'h3
`define THC_TERM_CEILING  3'h4
`define THC_FULL_SCALE    16'h2710
`define THC_PERCENT_100   32'h00000064
`define THC_CTRL_RESET    32'h00000001
`define THC_SP_RESET      16'h07D0
`define THC_HYST_RESET    16'h0032
`define THC_BAND_RESET    16'h01F4
`define THC_TI_RESET      16'h0096
`define THC_CYCLE_RESET   16'h0384
`define THC_CLOCK_HZ      20000000
`define THC_TICK_MS       1
`define THC_TICK_CYCLES   ((`THC_CLOCK_HZ / 1000) * `THC_TICK_MS)
`define THC_TICKS_PER_MIN 60000
`define THC_TICKS_PER_SEC 32'h000003E8
`define THC_RESP_OKAY     2'h0
`define THC_RESP_SLVERR   2'h2
`endif

// *** logic/thc_core.v ***
// room temperature controller: two-point, continuous pi and pwm pi
// What this block does
// - default heating: on below setpoint minus hysteresis, off at setpoint
// - default cooling: on above setpoint plus hysteresis, off below setpoint
// - every on or off decision goes out as its own actuator message
// - alternative heating: on below setpoint, off at setpoint plus hysteresis
// - alternative cooling: on above setpoint, off at setpoint minus hysteresis
// - separate heating and cooling hysteresis widths are held
// - by default band sits below setpoint heating, above it cooling
// - reversed band only selectable for floor or ceiling radiant panels
// - one setpoint per operating mode and per heating or cooling
// - error is setpoint minus temperature heating, reversed cooling
// - control variable is proportional term plus integral of error
// - gain is 100 over band; integral gain is gain over integral time
// - error at or above the band gives full output from p alone
// - constant error integrates one p-term per integral time
// - integral term is always included
// - pwm cycle: on for time proportional to output, off otherwise
// - setpoint change aborts the cycle, recomputes and restarts
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "thc_map.vh"
module thc_core #(
  parameter TICK_CYCLES = `THC_TICK_CYCLES
) (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rstn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // actuator messages and plant output
  output reg         o_msg_on,
  output reg         o_msg_off,
  output reg         o_plant_on,
  output reg  [15:0] o_control_variable
);
  // temperatures in 0.01 K, signed; output in 0.01 %
  reg  [31:0] ctrl_reg;
  reg  [15:0] temp_reg;
  reg  [15:0] sp_reg [0:7];
  reg  [15:0] hyst_heat_reg;
  reg  [15:0] hyst_cool_reg;
  reg  [15:0] band_reg;
  reg  [15:0] ti_reg;
  reg  [15:0] cycle_reg;
  reg  [31:0] integ_reg;
  reg  [31:0] tick_reg;
  reg  [31:0] pwm_reg;
  reg         sp_chg_reg;
  reg         aw_reg;
  reg         w_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  integer     k;

  wire        heat  = ctrl_reg[`THC_CTRL_HEAT];
  wire [1:0]  alg   = ctrl_reg[`THC_CTRL_ALG_HI:`THC_CTRL_ALG_LO];
  wire [1:0]  mode  = ctrl_reg[`THC_CTRL_MODE_HI:`THC_CTRL_MODE_LO];
  wire [2:0]  term  = ctrl_reg[`THC_CTRL_TERM_HI:`THC_CTRL_TERM_LO];
  wire        radiant = (term == `THC_TERM_FLOOR) ||
                        (term == `THC_TERM_CEILING);
  wire        alt   = ctrl_reg[`THC_CTRL_ALT] & radiant;
  wire [2:0]  sp_idx = {heat, mode};
  wire signed [31:0] sp   = {{16{sp_reg[sp_idx][15]}}, sp_reg[sp_idx]};
  wire signed [31:0] tm   = {{16{temp_reg[15]}}, temp_reg};
  wire signed [31:0] hyst = heat ? {16'h0000, hyst_heat_reg}
                                 : {16'h0000, hyst_cool_reg};
  wire signed [31:0] err  = heat ? sp - tm : tm - sp;

  function [31:0] clamp_full;
    input signed [31:0] v;
    begin
      if (v < 0)
        clamp_full = 32'h00000000;
      else if (v > $signed({16'h0000, `THC_FULL_SCALE}))
        clamp_full = {16'h0000, `THC_FULL_SCALE};
      else
        clamp_full = v;
    end
  endfunction

  // setpoint slots sit at consecutive words from the base offset
  function [2:0] sp_slot;
    input [7:0] addr;
    begin
      sp_slot = addr[4:2] - 3'h2;
    end
  endfunction

  function sp_in_range;
    input [7:0] addr;
    begin
      sp_in_range = (addr >= `THC_OFF_SP_BASE) && (addr < `THC_OFF_HYST);
    end
  endfunction

  // p = err * 10000 / band in percent-hundredths; band floored at 1
  wire [31:0] band_nz = (band_reg == 16'h0000) ? 32'h00000001
                                                : {16'h0000, band_reg};
  wire signed [31:0] p_raw = (err * $signed(`THC_PERCENT_100) * 100) /
                             $signed(band_nz);
  wire [31:0] ti_ticks = (ti_reg == 16'h0000) ? `THC_TICKS_PER_MIN :
                         ti_reg * `THC_TICKS_PER_MIN;
  // integ_reg holds p-sum scaled by ti_ticks; one ti of constant error
  // therefore adds one full p-term, trading width for exact ratio
  wire [31:0] i_term = integ_reg / ti_ticks;
  wire signed [31:0] cv_sum = p_raw + $signed(i_term);
  wire [31:0] cv = clamp_full(cv_sum);
  wire        sat_hi = cv_sum >= $signed({16'h0000, `THC_FULL_SCALE});
  wire        sat_lo = cv_sum <= 0;
  wire        tick = (tick_reg == TICK_CYCLES - 1);

  // two-point thresholds
  reg demand_on;
  reg demand_off;
  always @* begin
    if (heat && !alt) begin
      demand_on  = tm < sp - hyst;
      demand_off = tm >= sp;
    end else if (heat) begin
      demand_on  = tm < sp;
      demand_off = tm >= sp + hyst;
    end else if (!alt) begin
      demand_on  = tm > sp + hyst;
      demand_off = tm < sp;
    end else begin
      demand_on  = tm > sp;
      demand_off = tm <= sp - hyst;
    end
  end

  // multiply before dividing, or short cycles lose all resolution
  wire [31:0] cyc_ticks = cycle_reg * `THC_TICKS_PER_SEC;
  wire [47:0] on_prod   = cyc_ticks * cv;
  wire [47:0] on_quot   = on_prod / {32'h00000000, `THC_FULL_SCALE};
  wire [31:0] on_ticks  = on_quot[31:0];
  // continuous pi flags the plant on for any nonzero output
  reg         want_on;
  always @* begin
    case (alg)
      `THC_ALG_TWO_POINT:
        want_on = demand_on ? 1'b1 : demand_off ? 1'b0 : o_plant_on;
      `THC_ALG_PI_CONT:
        want_on = cv != 32'h00000000;
      `THC_ALG_PI_PWM:
        want_on = pwm_reg < on_ticks;
      default:
        want_on = 1'b0;
    endcase
  end

  // axi4-lite slave: address and data taken in either order
  assign s_axi_awready = !aw_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire   wr_go = aw_reg && w_reg;
  wire   sp_hit = wr_go && sp_in_range(awaddr_reg);

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `THC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `THC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl_reg <= `THC_CTRL_RESET;
      temp_reg <= `THC_SP_RESET;
      for (k = 0; k < 8; k = k + 1)
        sp_reg[k] <= `THC_SP_RESET;
      hyst_heat_reg <= `THC_HYST_RESET;
      hyst_cool_reg <= `THC_HYST_RESET;
      band_reg <= `THC_BAND_RESET;
      ti_reg <= `THC_TI_RESET;
      cycle_reg <= `THC_CYCLE_RESET;
      sp_chg_reg <= 1'b0;
    end else begin
      sp_chg_reg <= sp_hit;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `THC_RESP_OKAY;
        // byte lanes ignored below word level: fields are whole halves
        if (wstrb_reg != 4'h0) begin
          case (awaddr_reg)
            `THC_OFF_CTRL:  ctrl_reg <= {23'h000000, wdata_reg[8:0]};
            `THC_OFF_TEMP:  temp_reg <= wdata_reg[15:0];
            `THC_OFF_HYST: begin
              hyst_heat_reg <= wdata_reg[15:0];
              hyst_cool_reg <= wdata_reg[31:16];
            end
            `THC_OFF_PI: begin
              band_reg <= wdata_reg[15:0];
              ti_reg <= wdata_reg[31:16];
            end
            `THC_OFF_CYCLE: cycle_reg <= wdata_reg[15:0];
            default: begin
              if (sp_hit)
                sp_reg[sp_slot(awaddr_reg)] <= wdata_reg[15:0];
              else if (awaddr_reg != `THC_OFF_STATUS &&
                       awaddr_reg != `THC_OFF_CV)
                s_axi_bresp <= `THC_RESP_SLVERR;
            end
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `THC_RESP_OKAY;
        case (s_axi_araddr)
          `THC_OFF_CTRL:  s_axi_rdata <= ctrl_reg;
          `THC_OFF_TEMP:  s_axi_rdata <= {16'h0000, temp_reg};
          `THC_OFF_HYST:  s_axi_rdata <= {hyst_cool_reg, hyst_heat_reg};
          `THC_OFF_PI:    s_axi_rdata <= {ti_reg, band_reg};
          `THC_OFF_CYCLE: s_axi_rdata <= {16'h0000, cycle_reg};
          `THC_OFF_STATUS:
            s_axi_rdata <= {29'h00000000, alt, sat_hi, o_plant_on};
          `THC_OFF_CV:    s_axi_rdata <= {16'h0000, o_control_variable};
          default: begin
            if (sp_in_range(s_axi_araddr))
              s_axi_rdata <= {16'h0000,
                              sp_reg[sp_slot(s_axi_araddr)]};
            else begin
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= `THC_RESP_SLVERR;
            end
          end
        endcase
      end
    end
  end

  // control timing and outputs
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_reg <= 32'h00000000;
      integ_reg <= 32'h00000000;
      pwm_reg <= 32'h00000000;
      o_plant_on <= 1'b0;
      o_msg_on <= 1'b0;
      o_msg_off <= 1'b0;
      o_control_variable <= 16'h0000;
    end else begin
      tick_reg <= tick ? 32'h00000000 : tick_reg + 32'h00000001;
      o_control_variable <= cv[15:0];
      if (sp_chg_reg) begin
        pwm_reg <= 32'h00000000;
        tick_reg <= 32'h00000000;
      end else if (tick) begin
        pwm_reg <= (pwm_reg + 1 >= cyc_ticks) ? 32'h00000000
                                              : pwm_reg + 1;
        // anti-windup: hold the sum while pushing further into a rail
        if (!(sat_hi && p_raw > 0) && !(sat_lo && p_raw < 0) &&
            !($signed(integ_reg) + p_raw < 0))
          integ_reg <= integ_reg + p_raw;
      end
      o_plant_on <= want_on;
      o_msg_on  <= want_on && !o_plant_on;
      o_msg_off <= !want_on && o_plant_on;
    end
  end
endmodule

// *** verif/thc_actuator.sv ***
// remote actuator model: follows on and off messages
`timescale 1ns/1ps
module thc_actuator (
  // clock and reset
  input  wire       i_clock,
  input  wire       i_rstn,
  // messages from the core
  input  wire       i_msg_on,
  input  wire       i_msg_off,
  // plant state and message count
  output reg        o_state,
  output reg  [7:0] o_count
);
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_state <= 1'b0;
      o_count <= 8'h00;
    end else if (i_msg_on || i_msg_off) begin
      o_state <= i_msg_on;
      o_count <= o_count + 8'h01;
    end
  end
endmodule

// *** verif/thc_core_asserts.sv ***
// port assertions for the thermostat core
`timescale 1ns/1ps
module thc_core_asserts (
  // clock and reset
  input wire        i_clock,
  input wire        i_rstn,
  // bus answers
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // plant side
  input wire        o_msg_on,
  input wire        o_msg_off,
  input wire        o_plant_on,
  input wire [15:0] o_control_variable
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  property p_excl; !(o_msg_on && o_msg_off); endproperty
  a_excl: assert property (p_excl) else $error("both msgs");
  property p_onp; o_msg_on |=> !o_msg_on; endproperty
  a_onp: assert property (p_onp) else $error("on msg long");
  property p_offp; o_msg_off |=> !o_msg_off; endproperty
  a_offp: assert property (p_offp) else $error("off msg long");
  property p_ons; o_msg_on |-> o_plant_on; endproperty
  a_ons: assert property (p_ons) else $error("on msg, plant off");
  property p_offs; o_msg_off |-> !o_plant_on; endproperty
  a_offs: assert property (p_offs) else $error("off msg, plant on");
  property p_cv; o_control_variable <= 16'h2710; endproperty
  a_cv: assert property (p_cv) else $error("cv over full");
  property p_bh; s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bh: assert property (p_bh) else $error("b dropped");
  property p_rh; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rh: assert property (p_rh) else $error("r dropped");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("no read answer");
endmodule
bind thc_core thc_core_asserts u_chk (
  .i_clock(i_clock), .i_rstn(i_rstn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .o_msg_on(o_msg_on), .o_msg_off(o_msg_off),
  .o_plant_on(o_plant_on), .o_control_variable(o_control_variable));

// *** verif/thc_core_test.sv ***
// self-checking bench for the thermostat core
`timescale 1ns/1ps
module thc_core_test;
  logic        i_clock, i_rstn, aw, w, ar, awr, wrd, arr, bv, rv;
  logic        mon, moff, plant, act, pe, br, rr;
  logic [7:0]  awa, ara, acnt, ecnt;
  logic [31:0] wd, rdata, rdat;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] cv;
  int          num_errors, cmp_count, cyc, n, dly;
  thc_core #(.TICK_CYCLES(4)) uut (.i_clock(i_clock), .i_rstn(i_rstn),
    .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(w), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(ar), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .o_msg_on(mon),
    .o_msg_off(moff), .o_plant_on(plant), .o_control_variable(cv));
  thc_actuator u_act (.i_clock(i_clock), .i_rstn(i_rstn), .i_msg_on(mon),
    .i_msg_off(moff), .o_state(act), .o_count(acnt));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // ready lines may lag the answer by dly cycles, which the bus allows
  task axw(input logic [7:0] a, input logic [31:0] d);
    begin
      aw <= 1'b1;
      w <= 1'b1;
      awa <= a;
      wd <= d;
      br <= (dly == 0);
      do begin
        @(posedge i_clock);
        if (awr) aw <= 1'b0;
        if (wrd) w <= 1'b0;
      end while ((aw && !awr) || (w && !wrd));
      repeat (dly) @(posedge i_clock);
      br <= 1'b1;
      do @(posedge i_clock); while (!(bv && br));
      rsp = bresp;
    end
  endtask
  task axr(input logic [7:0] a);
    begin
      ar <= 1'b1;
      ara <= a;
      rr <= (dly == 0);
      do @(posedge i_clock); while (!arr);
      ar <= 1'b0;
      repeat (dly) @(posedge i_clock);
      rr <= 1'b1;
      do @(posedge i_clock); while (!(rv && rr));
      rdat = rdata;
      rsp = rresp;
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    begin
      axr(a);
      chk(rdat, e);
    end
  endtask
  // set mode and temperature, then plant, actuator and message count
  task step(input logic [31:0] c, input logic [31:0] t, input logic e);
    begin
      axw(8'h00, c);
      axw(8'h04, t);
      repeat (12) @(posedge i_clock);
      if (e !== pe) ecnt = ecnt + 8'h01;
      pe = e;
      chk({22'h0, plant, act, acnt}, {22'h0, e, e, ecnt});
    end
  endtask
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  initial begin
    {i_rstn, aw, w, ar, pe} = 5'h00;
    {br, rr} = 2'h3;
    {awa, ara, ecnt, wd} = 56'h0;
    {num_errors, cmp_count, cyc, dly} = 0;
    repeat (12) @(posedge i_clock);
    i_rstn <= 1'b1;
    rchk(8'h00, 32'h00000001);
    rchk(8'h10, 32'h000007D0);
    rchk(8'h28, 32'h00320032);
    rchk(8'h2C, 32'h009601F4);
    rchk(8'h30, 32'h00000384);
    rchk(8'h3C, 32'h00000000);
    chk({30'h0, rsp}, 32'h00000002);
    axw(8'h3C, 32'h00000001);
    chk({30'h0, rsp}, 32'h00000002);
    dly = 2;
    axw(8'h28, 32'h00C80064);
    rchk(8'h28, 32'h00C80064);
    dly = 0;
    $display("registers done");
    step(32'h01, 32'd1901, 1'b0);
    step(32'h01, 32'd1899, 1'b1);
    step(32'h01, 32'd1999, 1'b1);
    step(32'h01, 32'd2000, 1'b0);
    step(32'h00, 32'd2200, 1'b0);
    step(32'h00, 32'd2201, 1'b1);
    step(32'h00, 32'd2000, 1'b1);
    step(32'h00, 32'd1999, 1'b0);
    step(32'h03, 32'd1950, 1'b0);
    rchk(8'h34, 32'h00000000);
    step(32'hC3, 32'd1999, 1'b1);
    rchk(8'h34, 32'h00000005);
    step(32'hC3, 32'd2099, 1'b1);
    step(32'hC3, 32'd2100, 1'b0);
    step(32'hC2, 32'd2001, 1'b1);
    step(32'hC2, 32'd1801, 1'b1);
    step(32'hC2, 32'd1800, 1'b0);
    axw(8'h1C, 32'h000009C4);
    step(32'h11, 32'd2300, 1'b1);
    step(32'h11, 32'd2500, 1'b0);
    $display("two-point done");
    axw(8'h00, 32'h05);
    axw(8'h04, 32'd1500);
    repeat (40) @(posedge i_clock);
    chk({16'h0, cv}, 32'h00002710);
    rchk(8'h34, 32'h00000003);
    rchk(8'h38, 32'h00002710);
    axw(8'h04, 32'd1750);
    repeat (40) @(posedge i_clock);
    chk({31'h0, cv >= 16'h1388 && cv <= 16'h138A}, 32'h1);
    axw(8'h00, 32'h04);
    axw(8'h04, 32'd2250);
    repeat (40) @(posedge i_clock);
    chk({31'h0, cv >= 16'h1388 && cv <= 16'h138A}, 32'h1);
    $display("continuous done");
    axw(8'h30, 32'h01);
    axw(8'h00, 32'h09);
    axw(8'h04, 32'd1750);
    axw(8'h10, 32'h7D0);
    n = 0;
    repeat (4000) begin
      @(posedge i_clock);
      if (plant === 1'b1) n = n + 1;
    end
    chk({31'h0, n >= 1990 && n <= 2010}, 32'h1);
    while (plant !== 1'b0) @(posedge i_clock);
    axw(8'h10, 32'h7D0);
    repeat (12) @(posedge i_clock);
    chk({31'h0, plant}, 32'h1);
    $display("pwm done");
    test_done;
  end
endmodule
